// ==== hdl/lbpwm_pkg.sv ====
// Constants and register map of the LED blink and PWM output-control block
package lbpwm_pkg;

    localparam logic [7:0] ADDR_INPUT_LEVELS   = 8'h00;
    localparam logic [7:0] ADDR_PHASE_A        = 8'h02;
    localparam logic [7:0] ADDR_PORT_DIRECTION = 8'h06;
    localparam logic [7:0] ADDR_PHASE_B        = 8'h0a;
    localparam logic [7:0] ADDR_MASTER_NINTH   = 8'h0e;
    localparam logic [7:0] ADDR_CONFIG         = 8'h0f;
    localparam logic [7:0] ADDR_INTENSITY_BASE = 8'h10;
    localparam logic [7:0] ADDR_INTENSITY_LAST = 8'h13;

    localparam int CFG_BLINK_EN_BIT  = 0;
    localparam int CFG_FLIP_BIT      = 1;
    localparam int CFG_GLOBAL_BIT    = 2;
    localparam int CFG_IRQ_EN_BIT    = 3;
    localparam int CFG_NINTH_A_BIT   = 4;
    localparam int CFG_NINTH_B_BIT   = 5;
    localparam int CFG_BLINK_PIN_BIT = 6;

    localparam logic [7:0] RST_PHASE       = 8'hff;
    localparam logic [7:0] RST_DIRECTION   = 8'hff;
    localparam logic [7:0] RST_MASTER      = 8'h00;
    localparam logic [7:0] RST_CONFIG      = 8'h30;
    localparam logic [7:0] RST_INTENSITY   = 8'hff;

    localparam int          CLK_FREQ_HZ    = 20000000;
    localparam int          OSC_FREQ_HZ    = 32000;
    localparam int          OSC_DIV_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam logic [9:0]  OSC_DIV_LAST   = 10'(OSC_DIV_CYCLES - 1);
    localparam logic [3:0]  CYCLE_LAST     = 4'hf;
    localparam logic [3:0]  SLOT_LAST      = 4'he;
    localparam logic [3:0]  INTENSITY_FULL = 4'hf;

endpackage

// ==== hdl/lbpwm_output_ctrl.sv ====
// Output levels, blink selection and PWM engine with its register port
`timescale 1ns/1ps
module lbpwm_output_ctrl
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_valid,
    input  wire logic [7:0] port_in,
    output logic      [7:0] port_out,
    output logic      [7:0] port_oe,
    input  wire logic       blink_pin,
    output logic            ninth_out,
    output logic            ninth_oe
);

    logic [7:0]  port_meta_q;
    logic [7:0]  port_sync_q;
    logic        blink_meta_q;
    logic        blink_sync_q;
    logic [7:0]  phase_a_q;
    logic [7:0]  phase_b_q;
    logic [7:0]  port_dir_q;
    logic [7:0]  master_ninth_q;
    logic [7:0]  cfg_q;
    logic [31:0] intensity_q;
    logic [9:0]  div_cnt_q;
    logic        pwm_tick_q;
    logic [3:0]  cyc_q;
    logic [3:0]  slot_q;
    logic        sel_phase_q;
    logic [8:0]  lvl_q;
    logic [8:0]  static_vec;
    logic [8:0]  on_vec;
    logic [8:0]  drive_low_d;
    logic [8:0]  outen_vec;
    logic        osc_run;
    logic        apply_en;
    logic [3:0]  master;
    logic [9:0]  tick_gap_q;

    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        logic [7:0] r;
        r = 8'h00;
        unique case (addr)
            lbpwm_pkg::ADDR_INPUT_LEVELS:   r = port_sync_q;
            lbpwm_pkg::ADDR_PHASE_A:        r = phase_a_q;
            lbpwm_pkg::ADDR_PHASE_B:        r = phase_b_q;
            lbpwm_pkg::ADDR_PORT_DIRECTION: r = port_dir_q;
            lbpwm_pkg::ADDR_MASTER_NINTH:   r = master_ninth_q;
            lbpwm_pkg::ADDR_CONFIG:         r = {1'b0, blink_sync_q, cfg_q[5:0]};
            8'h10, 8'h11, 8'h12, 8'h13:     r = intensity_q[8*addr[1:0] +: 8];
            default:                        r = 8'h00;
        endcase
        return r;
    endfunction

    // Pins are asynchronous to ref_clk
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            port_meta_q  <= 8'h00;
            port_sync_q  <= 8'h00;
            blink_meta_q <= 1'b0;
            blink_sync_q <= 1'b0;
        end
        else
        begin
            port_meta_q  <= port_in;
            port_sync_q  <= port_meta_q;
            blink_meta_q <= blink_pin;
            blink_sync_q <= blink_meta_q;
        end
    end

    // Phase-0 levels
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            phase_a_q <= lbpwm_pkg::RST_PHASE;
        else if (reg_wr_en && reg_addr == lbpwm_pkg::ADDR_PHASE_A)
            phase_a_q <= reg_wdata;
    end

    // Phase-1 levels, only consulted while blinking
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            phase_b_q <= lbpwm_pkg::RST_PHASE;
        else if (reg_wr_en && reg_addr == lbpwm_pkg::ADDR_PHASE_B)
            phase_b_q <= reg_wdata;
    end

    // Direction, all inputs after reset so nothing is pulled low
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            port_dir_q <= lbpwm_pkg::RST_DIRECTION;
        else if (reg_wr_en && reg_addr == lbpwm_pkg::ADDR_PORT_DIRECTION)
            port_dir_q <= reg_wdata;
    end

    // Master and ninth intensity nibbles
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            master_ninth_q <= lbpwm_pkg::RST_MASTER;
        else if (reg_wr_en && reg_addr == lbpwm_pkg::ADDR_MASTER_NINTH)
            master_ninth_q <= reg_wdata;
    end

    // Configuration; top two bits are never stored, bit 6 reads back the blink pin and bit 7 reads 0
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            cfg_q <= lbpwm_pkg::RST_CONFIG;
        else if (reg_wr_en && reg_addr == lbpwm_pkg::ADDR_CONFIG)
            cfg_q <= {2'b00, reg_wdata[5:0]};
    end

    // Individual intensities, two nibbles per address
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            intensity_q <= {4{lbpwm_pkg::RST_INTENSITY}};
        else if (reg_wr_en && reg_addr >= lbpwm_pkg::ADDR_INTENSITY_BASE
                 && reg_addr <= lbpwm_pkg::ADDR_INTENSITY_LAST)
            intensity_q[8*reg_addr[1:0] +: 8] <= reg_wdata;
    end

    // Register reads, answered one cycle later
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
                reg_rdata <= read_mux(reg_addr);
        end
    end

    // Master zero means all static, so the oscillator is held
    assign master  = master_ninth_q[7:4];
    assign osc_run = (master != 4'h0);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !osc_run)
        begin
            div_cnt_q  <= 10'h000;
            pwm_tick_q <= 1'b0;
        end
        else if (div_cnt_q == lbpwm_pkg::OSC_DIV_LAST)
        begin
            div_cnt_q  <= 10'h000;
            pwm_tick_q <= 1'b1;
        end
        else
        begin
            div_cnt_q  <= div_cnt_q + 10'h001;
            pwm_tick_q <= 1'b0;
        end
    end

    // 16 cycles per slot, 15 slots per period
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !osc_run)
        begin
            cyc_q  <= 4'h0;
            slot_q <= 4'h0;
        end
        else if (pwm_tick_q)
        begin
            cyc_q <= cyc_q + 4'h1;
            if (cyc_q == lbpwm_pkg::CYCLE_LAST)
                slot_q <= (slot_q == lbpwm_pkg::SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
        end
    end

    // Level changes wait for a cycle boundary; no oscillator means no PWM edge to race
    assign apply_en = pwm_tick_q || !osc_run;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sel_phase_q <= 1'b0;
            lvl_q       <= 9'h1ff;
        end
        else if (apply_en)
        begin
            sel_phase_q <= cfg_q[lbpwm_pkg::CFG_BLINK_EN_BIT] & (cfg_q[lbpwm_pkg::CFG_FLIP_BIT] ^ blink_sync_q);
            if (cfg_q[lbpwm_pkg::CFG_BLINK_EN_BIT] & (cfg_q[lbpwm_pkg::CFG_FLIP_BIT] ^ blink_sync_q))
                lvl_q <= {cfg_q[lbpwm_pkg::CFG_NINTH_B_BIT], phase_b_q};
            else
                lvl_q <= {cfg_q[lbpwm_pkg::CFG_NINTH_A_BIT], phase_a_q};
        end
    end

    // Intensity per output; global nibble replaces all nine
    always_comb
    begin
        logic [3:0] n;
        n          = 4'h0;
        static_vec = 9'h000;
        on_vec     = 9'h000;
        for (int i = 0; i < 9; i++)
        begin
            if (cfg_q[lbpwm_pkg::CFG_GLOBAL_BIT] || i == 8)
                n = master_ninth_q[3:0];
            else
                n = intensity_q[4*i +: 4];
            static_vec[i] = !osc_run || (n == lbpwm_pkg::INTENSITY_FULL);
            on_vec[i]     = static_vec[i] || ((slot_q < master) && (cyc_q <= n));
        end
    end

    // Driven level is the bit in on-time, its opposite in off-time
    always_comb
    begin
        for (int i = 0; i < 9; i++)
            drive_low_d[i] = on_vec[i] ? !lvl_q[i] : lvl_q[i];
        outen_vec = {1'b1, ~port_dir_q};
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            port_oe   <= 8'h00;
            port_out  <= 8'h00;
            ninth_oe  <= 1'b0;
            ninth_out <= 1'b0;
        end
        else
        begin
            port_oe  <= drive_low_d[7:0] & outen_vec[7:0];
            ninth_oe <= drive_low_d[8];
        end
    end

    // Cycles since the last tick or oscillator start, for the period check
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !osc_run)
            tick_gap_q <= 10'h000;
        else if (pwm_tick_q)
            tick_gap_q <= 10'h001;
        else
            tick_gap_q <= tick_gap_q + 10'h001;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_input_not_driven: assert property (port_dir_q[0] |=> !port_oe[0])
        else $error("input port driven");
    a_phase_a_readback: assert property (reg_rd_en && reg_addr == lbpwm_pkg::ADDR_PHASE_A
        |=> reg_rd_valid && reg_rdata == $past(phase_a_q))
        else $error("phase-0 readback wrong");
    a_input_level_read: assert property (reg_rd_en && reg_addr == lbpwm_pkg::ADDR_INPUT_LEVELS
        |=> reg_rdata == $past(port_sync_q))
        else $error("input register wrong");
    a_blink_off_phase: assert property (apply_en && !cfg_q[lbpwm_pkg::CFG_BLINK_EN_BIT]
        |=> !sel_phase_q && lvl_q[7:0] == $past(phase_a_q))
        else $error("phase-1 used with blink off");
    a_blink_on_phase: assert property (apply_en && cfg_q[lbpwm_pkg::CFG_BLINK_EN_BIT]
        |=> sel_phase_q == $past(cfg_q[lbpwm_pkg::CFG_FLIP_BIT] ^ blink_sync_q))
        else $error("blink phase select wrong");
    a_osc_stopped: assert property (!osc_run |=> !pwm_tick_q && cyc_q == 4'h0)
        else $error("oscillator runs with PWM off");
    a_tick_spacing: assert property (pwm_tick_q |=> !pwm_tick_q [*8])
        else $error("ticks too close");
    a_period_wrap: assert property (osc_run && pwm_tick_q && cyc_q == 4'hf && slot_q == 4'he
        |=> cyc_q == 4'h0 && slot_q == 4'h0)
        else $error("period not 240 steps");
    a_static_level: assert property (!port_dir_q[0] && static_vec[0] |=> port_oe[0] == !$past(lvl_q[0]))
        else $error("static output not following level");
    a_ungated_off: assert property (!port_dir_q[0] && !static_vec[0] && slot_q >= master
        |=> port_oe[0] == $past(lvl_q[0]))
        else $error("output active outside master gate");

    a_tick_period: assert property (pwm_tick_q |-> tick_gap_q == lbpwm_pkg::OSC_DIV_LAST + 10'h001)
        else $error("tick period wrong");

    a_phase_b_readback: assert property (reg_rd_en && reg_addr == lbpwm_pkg::ADDR_PHASE_B
        |=> reg_rd_valid && reg_rdata == $past(phase_b_q))
        else $error("phase-1 readback wrong");

    a_dir_readback: assert property (reg_rd_en && reg_addr == lbpwm_pkg::ADDR_PORT_DIRECTION
        |=> reg_rdata == $past(port_dir_q))
        else $error("direction readback wrong");

    a_open_drain: assert property (1'b1 |=> port_out == 8'h00 && !ninth_out)
        else $error("open-drain output driven high");

    a_level_hold: assert property (!apply_en |=> $stable(lvl_q))
        else $error("level changed off a cycle boundary");

    a_ninth_phase_a: assert property (apply_en && !cfg_q[lbpwm_pkg::CFG_BLINK_EN_BIT]
        |=> lvl_q[8] == $past(cfg_q[lbpwm_pkg::CFG_NINTH_A_BIT]))
        else $error("ninth level wrong with blink off");

    a_slot_range: assert property (slot_q <= lbpwm_pkg::SLOT_LAST)
        else $error("slot counter out of range");

    a_global_same: assert property (cfg_q[lbpwm_pkg::CFG_GLOBAL_BIT] && !port_dir_q[0] && !port_dir_q[1]
        && lvl_q[0] == lvl_q[1] |=> port_oe[0] == port_oe[1])
        else $error("global intensity differs between outputs");

    a_gated_on: assert property (!port_dir_q[0] && !static_vec[0] && slot_q < master
        && !cfg_q[lbpwm_pkg::CFG_GLOBAL_BIT] && cyc_q <= intensity_q[3:0]
        |=> port_oe[0] == !$past(lvl_q[0]))
        else $error("output not on inside its duty");

    a_gated_off: assert property (!port_dir_q[0] && !static_vec[0] && slot_q < master
        && !cfg_q[lbpwm_pkg::CFG_GLOBAL_BIT] && cyc_q > intensity_q[3:0]
        |=> port_oe[0] == $past(lvl_q[0]))
        else $error("output on past its duty");

    c_blink_phase_b: cover property (sel_phase_q && apply_en);
    c_period_wrap:   cover property (pwm_tick_q && cyc_q == 4'hf && slot_q == 4'he);
    c_global_mode:   cover property (cfg_q[lbpwm_pkg::CFG_GLOBAL_BIT] && osc_run && port_oe[0]);
    c_ninth_low:     cover property (ninth_oe ##1 !ninth_oe);
    c_mixed_static:  cover property (osc_run && static_vec[1] && !static_vec[0]);

endmodule // lbpwm_output_ctrl

// ==== tb/lbpwm_pin_load.sv ====
// Far-side pin load: pull-up resistors plus an external low driver
`timescale 1ns/1ps
module lbpwm_pin_load
(
    input  wire logic [7:0] port_oe,
    input  wire logic [7:0] ext_low,
    output logic      [7:0] port_in
);
    // Released pins rise through pull-ups, so no stale level survives
    assign port_in = ~port_oe & ~ext_low;
endmodule // lbpwm_pin_load

// ==== tb/testbench.sv ====
// Self-checking bench for the output-control block
`timescale 1ns/1ps
module testbench;
    logic        ref_clk      = 1'b0;
    logic        sys_rst      = 1'b1;
    logic        reg_wr_en    = 1'b0;
    logic        reg_rd_en    = 1'b0;
    logic [7:0]  reg_addr     = 8'h00;
    logic [7:0]  reg_wdata    = 8'h00;
    logic        blink_pin    = 1'b0;
    logic [7:0]  ext_low      = 8'h00;
    logic [7:0]  reg_rdata;
    logic        reg_rd_valid;
    logic [7:0]  port_in;
    logic [7:0]  port_oe;
    logic [7:0]  port_out;
    logic        ninth_out;
    logic        ninth_oe;
    logic        sel;
    logic [15:0] c0, c1, c2;
    int          miscompares  = 0;
    int          num_checks   = 0;

    always #25 ref_clk = ~ref_clk;

    lbpwm_output_ctrl dut
    (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .reg_wr_en    (reg_wr_en),
        .reg_rd_en    (reg_rd_en),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_rdata    (reg_rdata),
        .reg_rd_valid (reg_rd_valid),
        .port_in      (port_in),
        .port_out     (port_out),
        .port_oe      (port_oe),
        .blink_pin    (blink_pin),
        .ninth_out    (ninth_out),
        .ninth_oe     (ninth_oe)
    );

    lbpwm_pin_load load
    (
        .port_oe (port_oe),
        .ext_low (ext_low),
        .port_in (port_in)
    );

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Strobe drops for a full cycle between calls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        int i;
        @(negedge ref_clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        i = 0;
        while (reg_rd_valid !== 1'b1 && i < 4)
        begin
            @(negedge ref_clk);
            i++;
        end
        if (i == 4)
        begin
            miscompares++;
            report_and_stop();
        end
        else
            chk8(n, e, reg_rdata);
    endtask

    initial
    begin
        settle(12);
        sys_rst = 1'b0;
        rc("phase_a", 8'h02, 8'hff);
        rc("phase_b", 8'h0a, 8'hff);
        rc("direction", 8'h06, 8'hff);
        rc("inputs", 8'h00, 8'hff);
        rc("unmapped", 8'h05, 8'h00);
        $display("Test reset values done");
        wr(8'h06, 8'h0f);
        wr(8'h02, 8'h5a);
        wr(8'h0a, 8'h3c);
        wr(8'h00, 8'h00);
        ext_low = 8'h03;
        settle(4);
        rc("direction", 8'h06, 8'h0f);
        rc("phase_a", 8'h02, 8'h5a);
        rc("phase_b", 8'h0a, 8'h3c);
        rc("inputs", 8'h00, 8'h5c);
        chk8("port_oe", 8'ha0, port_oe);
        chk8("port_out", 8'h00, port_out);
        chk8("ninth_out", 8'h00, {7'h00, ninth_out});
        $display("Test static levels done");
        // Every row of the blink selection table, ninth levels 0 then 1
        for (int k = 0; k < 8; k++)
        begin
            blink_pin = k[2];
            wr(8'h0f, {4'h2, 2'b00, k[1], k[0]});
            settle(6);
            sel = k[0] & (k[1] ^ k[2]);
            chk8("port_oe", sel ? 8'hc0 : 8'ha0, port_oe);
            chk8("ninth_oe", {7'h00, ~sel}, {7'h00, ninth_oe});
        end
        $display("Test blink selection done");
        wr(8'h0f, 8'h30);
        wr(8'h06, 8'h00);
        wr(8'h02, 8'hfc);
        wr(8'h10, 8'hf3);
        wr(8'h11, 8'hf3);
        wr(8'h0e, 8'hf3);
        // Master 15 gates every slot, so any 16-tick window is exact
        for (int g = 0; g < 2; g++)
        begin
            wr(8'h0f, g ? 8'h34 : 8'h30);
            settle(1300);
            c0 = 16'h0000;
            c1 = 16'h0000;
            c2 = 16'h0000;
            repeat (10000)
            begin
                @(negedge ref_clk);
                c0 = c0 + 16'(port_oe[0]);
                c1 = c1 + 16'(port_oe[1]);
                c2 = c2 + 16'(port_oe[2]);
            end
            chk16("duty_low", 16'h09c4, c0);
            chk16("static", g ? 16'h09c4 : 16'h2710, c1);
            chk16("duty_high", 16'h1d4c, c2);
            $display("Test PWM duty done");
        end
        report_and_stop();
    end
endmodule // testbench
